/* common/mvfs_pkg.sv */
/*
  Constants for the monitor value and fan status register bank: register
  offsets, reset values, fault codes and field layouts.
  Assumes the surrounding device supplies a simple byte-wide register access
  port already decoded from the two-wire serial engine.
*/
// Behaviour
// [R01] fan error bit per tach channel sets when count exceeds limit; host write clears
// [R02] zone 1a/1b/2a/2b and internal temperatures refresh automatically, read-only
// [R03] host may write the zone 4 temperature register
// [R04] zone 4 temperature may instead follow analog input eight when selected
// [R05] absent or faulty remote diode for zone 1 or 2 reads 80h
// [R06] filtered zone 1 and 2 registers hold spike-smoothed readings, read-only
// [R07] host smoothing control setting adjusts the zone 1 and 2 filter
// [R08] nine voltage readings each in own read-only byte register
// [R09] nominal voltage input reads C0h, three-quarters of full scale
// [R10] fan error register upper four bits read zero, writes ignored
package mvfs_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] MVFS_ADDR_Z1B_TEMP = 8'h06;
  localparam logic [7:0] MVFS_ADDR_Z2B_TEMP = 8'h07;
  localparam logic [7:0] MVFS_ADDR_Z1B_FILT = 8'h08;
  localparam logic [7:0] MVFS_ADDR_Z2B_FILT = 8'h09;
  localparam logic [7:0] MVFS_ADDR_FAN_ERR = 8'h4F;
  localparam logic [7:0] MVFS_ADDR_Z1A_TEMP = 8'h50;
  localparam logic [7:0] MVFS_ADDR_Z2A_TEMP = 8'h51;
  localparam logic [7:0] MVFS_ADDR_INT_TEMP = 8'h52;
  localparam logic [7:0] MVFS_ADDR_EXT_TEMP = 8'h53;
  localparam logic [7:0] MVFS_ADDR_Z1A_FILT = 8'h54;
  localparam logic [7:0] MVFS_ADDR_Z2A_FILT = 8'h55;
  localparam logic [7:0] MVFS_ADDR_VOLT1 = 8'h56;
  localparam logic [7:0] MVFS_ADDR_VOLT2 = 8'h57;
  localparam logic [7:0] MVFS_ADDR_VOLT3 = 8'h58;
  localparam logic [7:0] MVFS_ADDR_VOLT4 = 8'h5C;
  localparam logic [7:0] MVFS_ADDR_VOLT5 = 8'h5E;
  localparam logic [7:0] MVFS_ADDR_VOLT6 = 8'h62;
  localparam logic [7:0] MVFS_ADDR_VOLT7 = 8'h63;
  localparam logic [7:0] MVFS_ADDR_VOLT8 = 8'h64;
  localparam logic [7:0] MVFS_ADDR_VOLT9 = 8'h65;
  // smoothing control and zone 4 source select live here
  localparam logic [7:0] MVFS_ADDR_SMOOTH_CTRL = 8'h62 + 8'h5E;

  // ----------------------------------------------------------------------
  // values and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] MVFS_RESET_BYTE = 8'h00;
  localparam logic [7:0] MVFS_DIODE_FAULT = 8'h80;
  localparam logic [7:0] MVFS_NOMINAL_CODE = 8'hC0;
  localparam logic [3:0] MVFS_FAN_ERR_MASK = 4'hF;
  localparam int MVFS_NUM_TACH = 4;
  localparam int MVFS_NUM_VOLT = 9;
  localparam int MVFS_AIN8_IDX = 7;
  localparam int MVFS_SMOOTH_SHIFT_LSB = 0;
  localparam int MVFS_SMOOTH_SHIFT_MSB = 1;
  localparam int MVFS_SMOOTH_EN_BIT = 2;
  localparam int MVFS_EXT_SRC_BIT = 3;
  localparam logic [7:0] MVFS_SMOOTH_RESET = 8'h00;

endpackage : mvfs_pkg

/* rtl/mvfs_regs.sv */
/*
  Monitor value and fan status register bank: temperature value registers,
  filtered temperatures, voltage readings and sticky fan limit error flags.
  Assumes the serial protocol engine presents single-cycle read and write
  strobes with a byte address, and that measurement front ends deliver
  new samples with a one-cycle valid pulse.
*/
module mvfs_regs #(
  parameter int TACH_W = 16,
  parameter int ADC_W = 10
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // register access port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // temperature front end: index 0 z1a,1 z2a,2 z1b,3 z2b
  input wire logic temp_valid_i,
  input wire logic [31:0] remote_temp_i,
  input wire logic [3:0] diode_fault_i,
  input wire logic [7:0] internal_temp_i,
  // voltage front end: raw ADC codes, nine channels packed
  input wire logic volt_valid_i,
  input wire logic [mvfs_pkg::MVFS_NUM_VOLT*ADC_W-1:0] volt_raw_i,
  input wire logic [mvfs_pkg::MVFS_NUM_VOLT*ADC_W-1:0] volt_nominal_i,
  // tachometer comparisons
  input wire logic tach_valid_i,
  input wire logic [4*TACH_W-1:0] tach_count_i,
  input wire logic [4*TACH_W-1:0] tach_limit_i,
  // outputs to the fan control loop
  output logic [3:0] fan_error_o,
  output logic [7:0] ext_zone_temp_o
);
  import mvfs_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // scale raw code so that the nominal input lands on three-quarters scale
  function automatic logic [7:0] mvfs_scale(input logic [ADC_W-1:0] raw, input logic [ADC_W-1:0] nom);
    logic [ADC_W+8:0] prod;
    logic [ADC_W+8:0] quot;
    prod = {9'h000, raw} * {{(ADC_W+1){1'b0}}, MVFS_NOMINAL_CODE};
    quot = (nom == '0) ? '0 : prod / {9'h000, nom};
    mvfs_scale = (quot > {{(ADC_W+1){1'b0}}, 8'hFF}) ? 8'hFF : quot[7:0];
  endfunction : mvfs_scale

  // spike smoothing: step toward the new sample by 1/2^shift
  function automatic logic [7:0] mvfs_smooth(input logic [7:0] old, input logic [7:0] smp,
                                            input logic [1:0] shift, input logic en);
    logic signed [8:0] diff;
    logic signed [8:0] step;
    diff = $signed({1'b0, smp}) - $signed({1'b0, old});
    step = diff >>> shift;
    if (!en) begin
      mvfs_smooth = smp;
    end else if (step == 9'sh000 && diff != 9'sh000) begin
      mvfs_smooth = (diff > 9'sh000) ? old + 8'h01 : old - 8'h01; // avoid sticking one count short
    end else begin
      mvfs_smooth = 8'(old + step[7:0]);
    end
  endfunction : mvfs_smooth

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] temp_q [4];
  logic [7:0] filt_q [4];
  logic [7:0] int_temp_q;
  logic [7:0] ext_temp_q;
  logic [7:0] volt_q [MVFS_NUM_VOLT];
  logic [3:0] fan_err_q;
  logic [7:0] smooth_ctrl_q;
  logic [7:0] rdata_d;
  logic [3:0] tach_over;
  logic [7:0] remote_now [4];

  // remote diode samples with fault substitution
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      remote_now[i] = diode_fault_i[i] ? MVFS_DIODE_FAULT : remote_temp_i[i*8 +: 8]; // R05
    end
  end

  // automatic temperature refresh; host cannot write these
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) begin
        temp_q[i] <= MVFS_RESET_BYTE;
      end
      int_temp_q <= MVFS_RESET_BYTE;
    end else if (temp_valid_i) begin
      for (int i = 0; i < 4; i++) begin
        temp_q[i] <= remote_now[i]; // R02
      end
      int_temp_q <= internal_temp_i; // R02
    end
  end

  // refresh checks: values move only on a sample and a dead diode shows the fault code;
  // zones 2a and 1b are both watched, each for the fault code in its own reading and filtered copy
  chk_temp_ro: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R02
    !temp_valid_i
    |=> $stable(temp_q[0]) && $stable(int_temp_q))
    else $error("temperature changed without sample");
  chk_temp_sample: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R02
    temp_valid_i && !diode_fault_i[0]
    |=> temp_q[0] == $past(remote_temp_i[7:0]))
    else $error("zone 1a temperature not refreshed");
  chk_int_sample: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R02
    temp_valid_i
    |=> int_temp_q == $past(internal_temp_i))
    else $error("internal temperature not refreshed");
  chk_diode_fault: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R05
    temp_valid_i && diode_fault_i[2]
    |=> temp_q[2] == MVFS_DIODE_FAULT && filt_q[2] == MVFS_DIODE_FAULT)
    else $error("diode fault code missing");
  chk_diode_fault_z2a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R05
    temp_valid_i && diode_fault_i[1]
    |=> temp_q[1] == MVFS_DIODE_FAULT && filt_q[1] == MVFS_DIODE_FAULT)
    else $error("zone 2a diode fault code missing");

  // filtered copies; a faulted diode passes the fault code straight through
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) begin
        filt_q[i] <= MVFS_RESET_BYTE;
      end
    end else if (temp_valid_i) begin
      for (int i = 0; i < 4; i++) begin
        filt_q[i] <= diode_fault_i[i] ? MVFS_DIODE_FAULT : // R06
          mvfs_smooth(filt_q[i], remote_now[i], smooth_ctrl_q[MVFS_SMOOTH_SHIFT_MSB:MVFS_SMOOTH_SHIFT_LSB],
                      smooth_ctrl_q[MVFS_SMOOTH_EN_BIT]); // R07
      end
    end
  end

  // filter checks: hold between samples, bypass when disabled, never overshoot the sample
  chk_filt_ro: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R06
    !temp_valid_i
    |=> $stable(filt_q[1]))
    else $error("filtered value changed without sample");
  chk_filt_bypass: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R07
    temp_valid_i && !smooth_ctrl_q[MVFS_SMOOTH_EN_BIT] && !diode_fault_i[0]
    |=> filt_q[0] == $past(remote_temp_i[7:0]))
    else $error("unsmoothed filter does not follow sample");
  chk_filt_toward: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R06
    temp_valid_i && smooth_ctrl_q[MVFS_SMOOTH_EN_BIT] && !diode_fault_i[0] && remote_temp_i[7:0] > filt_q[0]
    |=> filt_q[0] > $past(filt_q[0]) && filt_q[0] <= $past(remote_temp_i[7:0]))
    else $error("smoothed value not stepping toward sample");

  // smoothing control, also selects zone 4 source
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      smooth_ctrl_q <= MVFS_SMOOTH_RESET;
    end else if (reg_wr_i && reg_addr_i == MVFS_ADDR_SMOOTH_CTRL) begin
      smooth_ctrl_q <= reg_wdata_i; // R07
    end
  end

  // control register takes the host byte
  chk_ctrl_write: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R07
    reg_wr_i && reg_addr_i == MVFS_ADDR_SMOOTH_CTRL
    |=> smooth_ctrl_q == $past(reg_wdata_i))
    else $error("smoothing control write lost");

  // zone 4: host write, or analog input eight when selected
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_temp_q <= MVFS_RESET_BYTE;
    end else if (smooth_ctrl_q[MVFS_EXT_SRC_BIT]) begin
      if (volt_valid_i) begin
        ext_temp_q <= mvfs_scale(volt_raw_i[MVFS_AIN8_IDX*ADC_W +: ADC_W],
                                 volt_nominal_i[MVFS_AIN8_IDX*ADC_W +: ADC_W]); // R04
      end
    end else if (reg_wr_i && reg_addr_i == MVFS_ADDR_EXT_TEMP) begin
      ext_temp_q <= reg_wdata_i; // R03
    end
  end

  // zone 4 checks: the selected source alone may change it
  chk_ext_write: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R03
    reg_wr_i && reg_addr_i == MVFS_ADDR_EXT_TEMP && !smooth_ctrl_q[MVFS_EXT_SRC_BIT]
    |=> ext_temp_q == $past(reg_wdata_i))
    else $error("zone 4 write lost");
  chk_ext_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R03
    !smooth_ctrl_q[MVFS_EXT_SRC_BIT] && !(reg_wr_i && reg_addr_i == MVFS_ADDR_EXT_TEMP)
    |=> $stable(ext_temp_q))
    else $error("zone 4 changed without host write");
  chk_ext_analog: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R04
    smooth_ctrl_q[MVFS_EXT_SRC_BIT] && !volt_valid_i
    |=> $stable(ext_temp_q))
    else $error("zone 4 changed without analog sample");
  chk_ext_nominal: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R04
    smooth_ctrl_q[MVFS_EXT_SRC_BIT] && volt_valid_i && volt_nominal_i[MVFS_AIN8_IDX*ADC_W +: ADC_W] != '0 &&
    volt_raw_i[MVFS_AIN8_IDX*ADC_W +: ADC_W] == volt_nominal_i[MVFS_AIN8_IDX*ADC_W +: ADC_W]
    |=> ext_temp_q == MVFS_NOMINAL_CODE)
    else $error("zone 4 from analog input not scaled");

  // voltage readings, scaled so nominal reads three-quarter scale
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < MVFS_NUM_VOLT; i++) begin
        volt_q[i] <= MVFS_RESET_BYTE;
      end
    end else if (volt_valid_i) begin
      for (int i = 0; i < MVFS_NUM_VOLT; i++) begin
        volt_q[i] <= mvfs_scale(volt_raw_i[i*ADC_W +: ADC_W], volt_nominal_i[i*ADC_W +: ADC_W]); // R08 R09
      end
    end
  end

  // voltage checks: nominal lands on C0h at both ends of the bank, readings hold between samples
  chk_nominal_code: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R08 R09
    volt_valid_i && volt_raw_i[ADC_W-1:0] == volt_nominal_i[ADC_W-1:0] && volt_nominal_i[ADC_W-1:0] != '0
    |=> volt_q[0] == MVFS_NOMINAL_CODE)
    else $error("nominal voltage not C0");
  chk_nominal_last: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R09
    volt_valid_i && volt_nominal_i[(MVFS_NUM_VOLT-1)*ADC_W +: ADC_W] != '0 &&
    volt_raw_i[(MVFS_NUM_VOLT-1)*ADC_W +: ADC_W] == volt_nominal_i[(MVFS_NUM_VOLT-1)*ADC_W +: ADC_W]
    |=> volt_q[MVFS_NUM_VOLT-1] == MVFS_NOMINAL_CODE)
    else $error("last channel nominal voltage not C0");
  chk_volt_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R08
    !volt_valid_i
    |=> $stable(volt_q[MVFS_NUM_VOLT-1]))
    else $error("voltage reading changed without sample");

  // tach comparison
  always_comb begin
    for (int i = 0; i < MVFS_NUM_TACH; i++) begin
      tach_over[i] = tach_valid_i && (tach_count_i[i*TACH_W +: TACH_W] > tach_limit_i[i*TACH_W +: TACH_W]);
    end
  end

  // sticky fan errors; write one clears, a new event in the same cycle wins
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fan_err_q <= MVFS_RESET_BYTE[3:0];
    end else begin
      fan_err_q <= (fan_err_q & ~((reg_wr_i && reg_addr_i == MVFS_ADDR_FAN_ERR) ?
                    (reg_wdata_i[3:0] & MVFS_FAN_ERR_MASK) : 4'h0)) | tach_over; // R01
    end
  end

  // sticky flags: set on an over-limit count, held until the host clears them;
  // a clear racing a fresh event must lose, or a stalled fan could go unreported
  chk_fan_err_set: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R01
    tach_over[0]
    |=> fan_err_q[0])
    else $error("fan error 0 not set");
  chk_fan_err_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R01
    fan_err_q[2] && !(reg_wr_i && reg_addr_i == MVFS_ADDR_FAN_ERR)
    |=> fan_err_q[2])
    else $error("fan error dropped without clear");
  chk_fan_err_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R01
    reg_wr_i && reg_addr_i == MVFS_ADDR_FAN_ERR && reg_wdata_i[0] && !tach_over[0]
    |=> !fan_err_q[0])
    else $error("fan error 0 not cleared");
  chk_fan_set_wins: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R01
    tach_over[3] && reg_wr_i && reg_addr_i == MVFS_ADDR_FAN_ERR && reg_wdata_i[3]
    |=> fan_err_q[3])
    else $error("clear won over new fan event");
  chk_fan_err_no_spur: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R01
    !fan_err_q[2] && !tach_over[2]
    |=> !fan_err_q[2])
    else $error("fan error 2 set without event");

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always_comb begin
    case (reg_addr_i)
      MVFS_ADDR_Z1A_TEMP: rdata_d = temp_q[0];
      MVFS_ADDR_Z2A_TEMP: rdata_d = temp_q[1];
      MVFS_ADDR_Z1B_TEMP: rdata_d = temp_q[2];
      MVFS_ADDR_Z2B_TEMP: rdata_d = temp_q[3];
      MVFS_ADDR_INT_TEMP: rdata_d = int_temp_q;
      MVFS_ADDR_EXT_TEMP: rdata_d = ext_temp_q;
      MVFS_ADDR_Z1A_FILT: rdata_d = filt_q[0];
      MVFS_ADDR_Z2A_FILT: rdata_d = filt_q[1];
      MVFS_ADDR_Z1B_FILT: rdata_d = filt_q[2];
      MVFS_ADDR_Z2B_FILT: rdata_d = filt_q[3];
      MVFS_ADDR_VOLT1: rdata_d = volt_q[0];
      MVFS_ADDR_VOLT2: rdata_d = volt_q[1];
      MVFS_ADDR_VOLT3: rdata_d = volt_q[2];
      MVFS_ADDR_VOLT4: rdata_d = volt_q[3];
      MVFS_ADDR_VOLT5: rdata_d = volt_q[4];
      MVFS_ADDR_VOLT6: rdata_d = volt_q[5];
      MVFS_ADDR_VOLT7: rdata_d = volt_q[6];
      MVFS_ADDR_VOLT8: rdata_d = volt_q[7];
      MVFS_ADDR_VOLT9: rdata_d = volt_q[8];
      MVFS_ADDR_FAN_ERR: rdata_d = {4'h0, fan_err_q}; // R10
      MVFS_ADDR_SMOOTH_CTRL: rdata_d = smooth_ctrl_q;
      default: rdata_d = MVFS_RESET_BYTE;
    endcase
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= MVFS_RESET_BYTE;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  // read answer checks for the status and zone 4 registers
  chk_fan_reserved: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
    reg_rd_i && reg_addr_i == MVFS_ADDR_FAN_ERR
    |=> reg_rvalid_o && reg_rdata_o[7:4] == 4'h0)
    else $error("fan error reserved bits nonzero");
  chk_fan_read_flags: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R01
    reg_rd_i && reg_addr_i == MVFS_ADDR_FAN_ERR
    |=> reg_rdata_o[3:0] == $past(fan_err_q))
    else $error("fan error flags misread");
  chk_ext_readback: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R03
    reg_rd_i && reg_addr_i == MVFS_ADDR_EXT_TEMP
    |=> reg_rdata_o == $past(ext_temp_q))
    else $error("zone 4 misread");

  // outputs toward fan control, registered copies
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fan_error_o <= MVFS_RESET_BYTE[3:0];
      ext_zone_temp_o <= MVFS_RESET_BYTE;
    end else begin
      fan_error_o <= fan_err_q;
      ext_zone_temp_o <= ext_temp_q;
    end
  end

  // the copies toward fan control trail their registers by exactly one cycle
  chk_fan_out_copy: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R01
    1'b1
    |=> fan_error_o == $past(fan_err_q))
    else $error("fan error output not a copy");
  chk_ext_out_copy: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R03
    1'b1
    |=> ext_zone_temp_o == $past(ext_temp_q))
    else $error("zone 4 output not a copy");

endmodule : mvfs_regs

/* tb/mvfs_host_model.sv */
/*
  Host side model of the register access port: single-byte reads and writes
  as the serial protocol engine hands them over.
  Assumes the bench calls each task from one process at a time.
*/
module mvfs_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // transfers
  // ----------------------------------------------------------------------
  // idle port at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // released lines show the inverse, so a stale address is never mistaken for a live one
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = addr;
    reg_wdata_o = data;
    @(posedge ref_clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~addr;
    reg_wdata_o = ~data;
  endtask : wr
  // answer is taken one cycle after the strobe edge, once settled
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic vld);
    @(posedge ref_clk_i);
    #1;
    reg_rd_o = 1'b1;
    reg_addr_o = addr;
    @(posedge ref_clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~addr;
    vld = reg_rvalid_i;
    data = reg_rdata_i;
  endtask : rd
endmodule : mvfs_host_model

/* tb/tb.sv */
/*
  Self-checking bench for the monitor value and fan status register bank.
  Assumes default parameters (TACH_W 16, ADC_W 10) and the host model.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mvfs_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic ref_clk, reset, wr, rd, rvalid;
  logic [2:0] vld_pulse;
  logic [31:0] remote_temp;
  logic [3:0] diode_fault, fan_error;
  logic [7:0] internal_temp, addr, wdata, rdata, ext_temp, d;
  logic [MVFS_NUM_VOLT*10-1:0] volt_raw, volt_nominal;
  logic [63:0] tach_count, tach_limit;
  logic v;
  int n_mismatch, comparisons, cycles;
  localparam logic [7:0] VADDR [9] = '{MVFS_ADDR_VOLT1, MVFS_ADDR_VOLT2, MVFS_ADDR_VOLT3, MVFS_ADDR_VOLT4,
    MVFS_ADDR_VOLT5, MVFS_ADDR_VOLT6, MVFS_ADDR_VOLT7, MVFS_ADDR_VOLT8, MVFS_ADDR_VOLT9};
  localparam logic [7:0] TADDR [9] = '{MVFS_ADDR_Z1A_TEMP, MVFS_ADDR_Z2A_TEMP, MVFS_ADDR_Z1B_TEMP,
    MVFS_ADDR_Z2B_TEMP, MVFS_ADDR_INT_TEMP, MVFS_ADDR_Z1A_FILT, MVFS_ADDR_Z2A_FILT, MVFS_ADDR_Z1B_FILT,
    MVFS_ADDR_Z2B_FILT};
  localparam logic [7:0] TEXP [9] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h11, 8'h22, 8'h33, 8'h44};
  // ----------------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------------
  mvfs_host_model host_u (.ref_clk_i(ref_clk), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
  mvfs_regs dut_u (.ref_clk_i(ref_clk), .reset_i(reset), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .temp_valid_i(vld_pulse[0]),
    .remote_temp_i(remote_temp), .diode_fault_i(diode_fault), .internal_temp_i(internal_temp),
    .volt_valid_i(vld_pulse[1]), .volt_raw_i(volt_raw), .volt_nominal_i(volt_nominal),
    .tach_valid_i(vld_pulse[2]), .tach_count_i(tach_count), .tach_limit_i(tach_limit),
    .fan_error_o(fan_error), .ext_zone_temp_o(ext_temp));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, d, v);
    chk("read valid", {7'h00, v}, 8'h01);
    chk($sformatf("register %h", a), d, exp);
    // valid must drop again after its single cycle
    @(posedge ref_clk);
    #1;
    chk("read valid low", {7'h00, rvalid}, 8'h00);
  endtask : rchk
  // one-cycle valid pulse on the selected front ends
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk);
    #1;
    vld_pulse = m;
    @(posedge ref_clk);
    #1;
    vld_pulse = 3'h0;
  endtask : pulse
  // scaled code: nominal lands on three-quarters of full scale, saturating
  function automatic logic [7:0] vexp(input int raw, input int nom);
    int q;
    q = raw * 192 / nom;
    return (q > 255) ? 8'hFF : q[7:0];
  endfunction : vexp
  task automatic test_done();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------------
  // clock, timeout and sequence
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // a hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    reset = 1'b1;
    vld_pulse = 3'h0;
    remote_temp = 32'h0;
    diode_fault = 4'h0;
    internal_temp = 8'h00;
    volt_raw = '0;
    volt_nominal = '0;
    tach_count = 64'h0;
    tach_limit = 64'h0;
    repeat (20) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    foreach (TADDR[i]) rchk(TADDR[i], 8'h00);
    foreach (VADDR[i]) rchk(VADDR[i], 8'h00);
    rchk(MVFS_ADDR_FAN_ERR, 8'h00);
    remote_temp = 32'h44332211;
    internal_temp = 8'h55;
    pulse(3'h1);
    foreach (TADDR[i]) rchk(TADDR[i], TEXP[i]);
    host_u.wr(MVFS_ADDR_Z1A_TEMP, 8'hFF);
    rchk(MVFS_ADDR_Z1A_TEMP, 8'h11);
    host_u.wr(MVFS_ADDR_SMOOTH_CTRL, 8'h05);
    remote_temp[7:0] = 8'h31;
    pulse(3'h1);
    rchk(MVFS_ADDR_Z1A_FILT, 8'h21);
    rchk(MVFS_ADDR_Z1A_TEMP, 8'h31);
    diode_fault = 4'h6;
    pulse(3'h1);
    rchk(MVFS_ADDR_Z2A_TEMP, 8'h80);
    rchk(MVFS_ADDR_Z2A_FILT, 8'h80);
    rchk(MVFS_ADDR_Z1B_TEMP, 8'h80);
    rchk(MVFS_ADDR_Z1B_FILT, 8'h80);
    diode_fault = 4'h0;
    host_u.wr(MVFS_ADDR_EXT_TEMP, 8'h5A);
    rchk(MVFS_ADDR_EXT_TEMP, 8'h5A);
    chk("ext_zone_temp_o", ext_temp, 8'h5A);
    host_u.wr(MVFS_ADDR_SMOOTH_CTRL, 8'h08);
    host_u.wr(MVFS_ADDR_EXT_TEMP, 8'h11);
    rchk(MVFS_ADDR_EXT_TEMP, 8'h5A);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 9; i++) begin
        volt_nominal[i*10+:10] = 10'(p ? 256 : 100 * (i + 1));
        volt_raw[i*10+:10] = 10'(p ? 110 * (i + 1) : 100 * (i + 1));
      end
      pulse(3'h2);
      foreach (VADDR[i]) rchk(VADDR[i], vexp(p ? 110 * (i + 1) : 100 * (i + 1), p ? 256 : 100 * (i + 1)));
      rchk(MVFS_ADDR_EXT_TEMP, vexp(p ? 880 : 800, p ? 256 : 800));
      chk("ext_zone_temp_o", ext_temp, vexp(p ? 880 : 800, p ? 256 : 800));
    end
    tach_limit = {4{16'h03E8}};
    tach_count = {16'h03E7, 16'hFFFF, 16'h03E8, 16'h03E9};
    pulse(3'h4);
    rchk(MVFS_ADDR_FAN_ERR, 8'h05);
    chk("fan_error_o", {4'h0, fan_error}, 8'h05);
    tach_count = 64'h0;
    pulse(3'h4);
    rchk(MVFS_ADDR_FAN_ERR, 8'h05);
    host_u.wr(MVFS_ADDR_FAN_ERR, 8'hF1);
    rchk(MVFS_ADDR_FAN_ERR, 8'h04);
    tach_count[63:48] = 16'hFFFF;
    fork
      host_u.wr(MVFS_ADDR_FAN_ERR, 8'h0C);
      pulse(3'h4);
    join
    rchk(MVFS_ADDR_FAN_ERR, 8'h08);
    test_done();
  end
endmodule : tb
